/* rtl/bxt_pkg.sv */
// package: constants, register map and carrier types of the bus transceiver
package bxt_pkg;

    // ----------------------------------------------------------------
    // data path
    // ----------------------------------------------------------------
    localparam int unsigned BXT_DATA_W = 18;
    localparam int unsigned BXT_DIRS   = 2;
    localparam int unsigned BXT_DIR_AB = 0;
    localparam int unsigned BXT_DIR_BA = 1;

    // ----------------------------------------------------------------
    // register map (byte offsets)
    // ----------------------------------------------------------------
    localparam int unsigned BXT_OFS_W        = 12;
    localparam logic [11:0] BXT_OFS_STORE_AB = 12'h000;
    localparam logic [11:0] BXT_OFS_STORE_BA = 12'h004;
    localparam logic [11:0] BXT_OFS_PINS     = 12'h008;
    localparam logic [11:0] BXT_OFS_CTRL     = 12'h00C;

    // ctrl fields and reset values
    localparam int unsigned BXT_CTRL_W     = 2;
    localparam logic [1:0]  BXT_CTRL_RST   = 2'h3;
    localparam logic [31:0] BXT_WORD_ZERO  = 32'h0000_0000;
    localparam logic        BXT_OE_N_RST   = 1'b1;

    // ahb
    localparam int unsigned BXT_HTRANS_ACT = 1;
    localparam logic        BXT_HRESP_OKAY = 1'b0;

    // ----------------------------------------------------------------
    // carrier types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic out_en_n;
        logic latch_en;
        logic clk;
        logic clk_gate_n;
    } bxt_ctl_t;

    localparam int unsigned BXT_CTL_W = $bits(bxt_ctl_t);

    // idle pin levels: released, opaque, clock low, gate off
    localparam bxt_ctl_t BXT_CTL_IDLE = '{out_en_n: 1'b1, latch_en: 1'b0, clk: 1'b0, clk_gate_n: 1'b1};

endpackage

/* rtl/bxt_transceiver.sv */
// module: two-way latched/clocked bus transceiver with an ahb-lite status and control slave
//
// Our own choices: the address map and register access over AHB-Lite.
`timescale 1ns/1ps

// Operation
// RULE1 - two independent 18-bit paths, a to b and b to a, each own storage and controls
// RULE2 - latch enable high: storage follows port a data continuously
// RULE3 - latch enable low and clock steady: stored data held
// RULE4 - latch enable low, clock gated on: capture port data on each clock rising edge
// RULE5 - active-low clock gate per direction; edges store only while gate is low
// RULE6 - gate high and latch enable low: output keeps its level despite clock activity
// RULE7 - output enable low: stored data actively driven onto the far port; the code drives only while that direction's ctrl bit is set
// RULE8 - output enable high: far port released to high impedance, storage continues
// RULE9 - b to a path identical, using its own four controls
// RULE10 - latch enable falling keeps the value present at that fall
module bxt_transceiver #(
    parameter int unsigned WIDTH = bxt_pkg::BXT_DATA_W
) (
    // clock and reset
    input  wire logic             hclk,
    input  wire logic             hresetn,
    // ahb-lite slave
    input  wire logic             hsel,
    input  wire logic [31:0]      haddr,
    input  wire logic [1:0]       htrans,
    input  wire logic             hwrite,
    input  wire logic [2:0]       hsize,
    input  wire logic [31:0]      hwdata,
    input  wire logic             hready,
    output logic                  hreadyout,
    output logic                  hresp,
    output logic [31:0]           hrdata,
    // a to b controls
    input  wire logic             a_to_b_output_enable_n,
    input  wire logic             a_to_b_latch_enable,
    input  wire logic             a_to_b_clock,
    input  wire logic             a_to_b_clock_gate_n,
    // b to a controls
    input  wire logic             b_to_a_output_enable_n,
    input  wire logic             b_to_a_latch_enable,
    input  wire logic             b_to_a_clock,
    input  wire logic             b_to_a_clock_gate_n,
    // port a pins
    input  wire logic [WIDTH-1:0] port_a_in,
    output logic      [WIDTH-1:0] port_a_out,
    output logic                  port_a_oe_n,
    // port b pins
    input  wire logic [WIDTH-1:0] port_b_in,
    output logic      [WIDTH-1:0] port_b_out,
    output logic                  port_b_oe_n
);

    // ----------------------------------------------------------------
    // pin grouping
    // ----------------------------------------------------------------
    bxt_pkg::bxt_ctl_t ctl_raw  [bxt_pkg::BXT_DIRS];
    logic [WIDTH-1:0]  data_raw [bxt_pkg::BXT_DIRS];
    bxt_pkg::bxt_ctl_t ctl_sync [bxt_pkg::BXT_DIRS];
    logic [WIDTH-1:0]  stored   [bxt_pkg::BXT_DIRS];
    logic              drive_n  [bxt_pkg::BXT_DIRS];
    logic [bxt_pkg::BXT_CTRL_W-1:0] ctrl;

    assign ctl_raw[bxt_pkg::BXT_DIR_AB]  = '{out_en_n:   a_to_b_output_enable_n,
                                              latch_en:   a_to_b_latch_enable,
                                              clk:        a_to_b_clock,
                                              clk_gate_n: a_to_b_clock_gate_n};
    assign ctl_raw[bxt_pkg::BXT_DIR_BA]  = '{out_en_n:   b_to_a_output_enable_n,
                                              latch_en:   b_to_a_latch_enable,
                                              clk:        b_to_a_clock,
                                              clk_gate_n: b_to_a_clock_gate_n}; // see RULE9
    assign data_raw[bxt_pkg::BXT_DIR_AB] = port_a_in;
    assign data_raw[bxt_pkg::BXT_DIR_BA] = port_b_in;

    // ----------------------------------------------------------------
    // per-direction storage path
    // ----------------------------------------------------------------
    // data and controls share the same two-stage synchroniser so that a
    // clock edge is always paired with the data that stood beside it
    for (genvar d = 0; d < bxt_pkg::BXT_DIRS; d++)
    begin : g_dir
        bxt_pkg::bxt_ctl_t ctl_s1;
        bxt_pkg::bxt_ctl_t ctl_s2;
        logic              clk_prev;
        logic [WIDTH-1:0]  data_s1;
        logic [WIDTH-1:0]  data_s2;
        logic [WIDTH-1:0]  store;
        logic              oe_n;
        bxt_pkg::bxt_ctl_t next_ctl_s1;
        bxt_pkg::bxt_ctl_t next_ctl_s2;
        logic              next_clk_prev;
        logic [WIDTH-1:0]  next_data_s1;
        logic [WIDTH-1:0]  next_data_s2;
        logic [WIDTH-1:0]  next_store;
        logic              next_oe_n;
        logic              rise;

        always_comb
        begin
            next_ctl_s1   = ctl_raw[d];
            next_ctl_s2   = ctl_s1;
            next_data_s1  = data_raw[d];
            next_data_s2  = data_s1;
            next_clk_prev = ctl_s2.clk;
            rise          = ctl_s2.clk & ~clk_prev;
            next_store    = store;                                      // see RULE3, see RULE6, see RULE10
            if (ctl_s2.latch_en)
            begin
                next_store = data_s2;                                   // see RULE2
            end
            else if (rise && !ctl_s2.clk_gate_n)
            begin
                next_store = data_s2;                                   // see RULE4, see RULE5
            end
            // software may additionally hold a port released; storage is unaffected
            next_oe_n = ctl_s2.out_en_n | ~ctrl[d];                     // see RULE7, see RULE8
        end

        always_ff @(posedge hclk or negedge hresetn)
        begin
            if (!hresetn)
            begin
                // restart as idle pins: no false drive and no false clock edge after reset
                ctl_s1   <= bxt_pkg::BXT_CTL_IDLE;
                ctl_s2   <= bxt_pkg::BXT_CTL_IDLE;
                clk_prev <= 1'b0;
                data_s1  <= '0;
                data_s2  <= '0;
                store    <= '0;
                oe_n     <= bxt_pkg::BXT_OE_N_RST;
            end
            else
            begin
                ctl_s1   <= next_ctl_s1;
                ctl_s2   <= next_ctl_s2;
                clk_prev <= next_clk_prev;
                data_s1  <= next_data_s1;
                data_s2  <= next_data_s2;
                store    <= next_store;
                oe_n     <= next_oe_n;
            end
        end

        assign ctl_sync[d] = ctl_s2;
        assign stored[d]   = store;                                     // see RULE1
        assign drive_n[d]  = oe_n;
    end

    // ----------------------------------------------------------------
    // pin outputs
    // ----------------------------------------------------------------
    assign port_b_out  = stored[bxt_pkg::BXT_DIR_AB];                   // see RULE7
    assign port_b_oe_n = drive_n[bxt_pkg::BXT_DIR_AB];                  // see RULE8
    assign port_a_out  = stored[bxt_pkg::BXT_DIR_BA];                   // see RULE9
    assign port_a_oe_n = drive_n[bxt_pkg::BXT_DIR_BA];                  // see RULE9

    // ----------------------------------------------------------------
    // ahb-lite slave
    // ----------------------------------------------------------------
    // zero wait states: read data is prepared in the address phase
    logic                         wr_pend;
    logic [bxt_pkg::BXT_OFS_W-1:0] wr_ofs;
    logic                         next_wr_pend;
    logic [bxt_pkg::BXT_OFS_W-1:0] next_wr_ofs;
    logic [bxt_pkg::BXT_CTRL_W-1:0] next_ctrl;
    logic [31:0]                  next_hrdata;
    logic                         addr_ok;
    logic [bxt_pkg::BXT_OFS_W-1:0] ofs;

    assign hreadyout = 1'b1;
    assign hresp     = bxt_pkg::BXT_HRESP_OKAY;

    always_comb
    begin
        ofs          = haddr[bxt_pkg::BXT_OFS_W-1:0];
        addr_ok      = hsel & hready & htrans[bxt_pkg::BXT_HTRANS_ACT];
        next_wr_pend = addr_ok & hwrite;
        next_wr_ofs  = addr_ok ? ofs : wr_ofs;
        next_ctrl    = ctrl;
        if (wr_pend && wr_ofs == bxt_pkg::BXT_OFS_CTRL)
        begin
            next_ctrl = hwdata[bxt_pkg::BXT_CTRL_W-1:0];
        end
        next_hrdata = bxt_pkg::BXT_WORD_ZERO;
        if (addr_ok && !hwrite)
        begin
            unique case (ofs)
                bxt_pkg::BXT_OFS_STORE_AB: next_hrdata = 32'(stored[bxt_pkg::BXT_DIR_AB]);
                bxt_pkg::BXT_OFS_STORE_BA: next_hrdata = 32'(stored[bxt_pkg::BXT_DIR_BA]);
                bxt_pkg::BXT_OFS_PINS:     next_hrdata = 32'({ctl_sync[bxt_pkg::BXT_DIR_BA],
                                                              ctl_sync[bxt_pkg::BXT_DIR_AB]});
                bxt_pkg::BXT_OFS_CTRL:     next_hrdata = 32'(ctrl);
                default:                   next_hrdata = bxt_pkg::BXT_WORD_ZERO;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend <= 1'b0;
            wr_ofs  <= '0;
            ctrl    <= bxt_pkg::BXT_CTRL_RST;
            hrdata  <= bxt_pkg::BXT_WORD_ZERO;
        end
        else
        begin
            wr_pend <= next_wr_pend;
            wr_ofs  <= next_wr_ofs;
            ctrl    <= next_ctrl;
            hrdata  <= next_hrdata;
        end
    end

endmodule

/* bench/bxt_transceiver_props.sv */
// checker: port-level assertions for the bus transceiver
`timescale 1ns/1ps
module bxt_transceiver_props (
    // clock and reset
    input logic        hclk,
    input logic        hresetn,
    // pins
    input logic        a_to_b_output_enable_n,
    input logic        a_to_b_latch_enable,
    input logic        a_to_b_clock,
    input logic        a_to_b_clock_gate_n,
    input logic        b_to_a_output_enable_n,
    input logic        b_to_a_latch_enable,
    input logic        b_to_a_clock_gate_n,
    input logic [17:0] port_a_in,
    input logic [17:0] port_a_out,
    input logic        port_a_oe_n,
    input logic [17:0] port_b_in,
    input logic [17:0] port_b_out,
    input logic        port_b_oe_n
);
    // pin pipelines restart from zero, so relations wait a few edges after reset
    logic [2:0] run_cnt;
    logic       settled;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            run_cnt <= 3'h0;
        else if (run_cnt != 3'h7)
            run_cnt <= run_cnt + 3'h1;
    end
    assign settled = (run_cnt == 3'h7);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    chk_transp_ab:
        assert property ((a_to_b_latch_enable && $stable(port_a_in) && settled)[*4] |-> port_b_out == port_a_in)
        else $error("b out not following a");
    chk_transp_ba:
        assert property ((b_to_a_latch_enable && $stable(port_b_in) && settled)[*4] |-> port_a_out == port_b_in)
        else $error("a out not following b");
    chk_oe_off_ab:
        assert property ((a_to_b_output_enable_n && settled)[*4] |-> port_b_oe_n)
        else $error("port b driven while disabled");
    chk_oe_off_ba:
        assert property ((b_to_a_output_enable_n && settled)[*4] |-> port_a_oe_n)
        else $error("port a driven while disabled");
    chk_hold_steady_ab:
        assert property ((!a_to_b_latch_enable && $stable(a_to_b_clock) && settled)[*6] |-> $stable(port_b_out))
        else $error("b out changed while latched");
    chk_hold_gate_ab:
        assert property ((!a_to_b_latch_enable && a_to_b_clock_gate_n && settled)[*6] |-> $stable(port_b_out))
        else $error("b out changed while gated");
    chk_hold_gate_ba:
        assert property ((!b_to_a_latch_enable && b_to_a_clock_gate_n && settled)[*6] |-> $stable(port_a_out))
        else $error("a out changed while gated");
    chk_capture_ab:
        assert property (settled && !a_to_b_latch_enable && !$past(a_to_b_latch_enable) && !a_to_b_clock_gate_n
            && $rose(a_to_b_clock) && $stable(port_a_in) |-> ##3 port_b_out == $past(port_a_in, 3))
        else $error("clock edge did not capture a");
endmodule

bind bxt_transceiver bxt_transceiver_props bxt_transceiver_props_i (.hclk, .hresetn, .a_to_b_output_enable_n,
    .a_to_b_latch_enable, .a_to_b_clock, .a_to_b_clock_gate_n, .b_to_a_output_enable_n, .b_to_a_latch_enable,
    .b_to_a_clock_gate_n, .port_a_in, .port_a_out, .port_a_oe_n, .port_b_in, .port_b_out, .port_b_oe_n);

/* bench/bxt_far_bus.sv */
// model: other logic on one port, driving the bus while the transceiver releases it
`timescale 1ns/1ps
module bxt_far_bus (
    // transceiver side and far logic
    input  logic        oe_n,
    input  logic [17:0] dev_out,
    input  logic [17:0] far_data,
    output logic [17:0] pin
);
    // far logic yields whenever the transceiver drives, so the wire never contends
    assign pin = oe_n ? far_data : dev_out;
endmodule

/* bench/bxt_transceiver_tb_top.sv */
// testbench: random and corner stimulus for the bus transceiver
`timescale 1ns/1ps
module bxt_transceiver_tb_top;
    logic              hclk = 1'b0;
    logic              hresetn = 1'b0;
    logic              hsel, hwrite, hready, hresp, a_oe_n, b_oe_n;
    logic [1:0]        htrans;
    logic [2:0]        hsize;
    logic [31:0]       haddr, hwdata, hrdata;
    logic [17:0]       pin_a, pin_b, a_out, b_out;
    logic [17:0]       fd [2];
    bxt_pkg::bxt_ctl_t ctl [2];
    int                errors = 0;
    int                checked = 0;
    bxt_transceiver bxt_transceiver_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready, .hreadyout(hready), .hresp, .hrdata, .a_to_b_output_enable_n(ctl[0].out_en_n),
        .a_to_b_latch_enable(ctl[0].latch_en), .a_to_b_clock(ctl[0].clk), .a_to_b_clock_gate_n(ctl[0].clk_gate_n),
        .b_to_a_output_enable_n(ctl[1].out_en_n), .b_to_a_latch_enable(ctl[1].latch_en),
        .b_to_a_clock(ctl[1].clk), .b_to_a_clock_gate_n(ctl[1].clk_gate_n), .port_a_in(pin_a),
        .port_a_out(a_out), .port_a_oe_n(a_oe_n), .port_b_in(pin_b), .port_b_out(b_out), .port_b_oe_n(b_oe_n));
    bxt_far_bus bxt_far_bus_i [1:0] (.oe_n({b_oe_n, a_oe_n}), .dev_out({b_out, a_out}),
        .far_data({fd[1], fd[0]}), .pin({pin_b, pin_a}));
    initial
    begin
        forever #10 hclk = ~hclk;
    end
    function automatic logic [17:0] out_of(input int d);
        return d ? a_out : b_out;
    endfunction
    function automatic logic exp_oe(input logic allow, input logic oe_n);
        return !(allow && !oe_n);
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic ahb(input logic wr, input logic [31:0] addr, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge hclk);
        {hsel, htrans, haddr, hwrite, hsize} <= {1'b1, 2'h2, addr, wr, 3'h2};
        do @(posedge hclk); while (hready !== 1'b1);
        {hsel, htrans, hwdata} <= {1'b0, 2'h0, wd};
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic go(input int d, input logic le, input int n);
        ctl[d].latch_en <= le;
        ctl[d].out_en_n <= 1'b0;
        ctl[1-d].latch_en <= 1'b0;
        ctl[1-d].out_en_n <= 1'b1;
        repeat (n) @(posedge hclk);
    endtask
    task automatic pulse(input int d);
        ctl[d].clk <= 1'b1;
        repeat (3) @(posedge hclk);
        ctl[d].clk <= 1'b0;
        repeat (5) @(posedge hclk);
    endtask
    task automatic end_sim();
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // a hang ends as a mismatch
    initial
    begin
        repeat (5000) @(posedge hclk);
        errors++;
        end_sim();
    end
    initial
    begin
        logic [31:0] rd;
        logic [17:0] v [3];
        void'($urandom(20));
        {hsel, htrans, haddr, hwrite, hwdata, hsize} = '0;
        ctl[0] = bxt_pkg::BXT_CTL_IDLE;
        ctl[1] = bxt_pkg::BXT_CTL_IDLE;
        fd[0] = 18'h0_0000;
        fd[1] = 18'h0_0000;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        for (int k = 0; k < 3; k++)
        begin
            ahb(1'b0, 32'(k * 4 + 8), 32'h0000_0000, rd);
            chk(rd, (k == 0) ? 32'({ctl[1], ctl[0]})
                : (k == 1) ? 32'(bxt_pkg::BXT_CTRL_RST) : 32'h0000_0000);
            chk(32'(hresp), 32'(bxt_pkg::BXT_HRESP_OKAY));
        end
        for (int i = 0; i < 8; i++)
        begin
            fd[i%2] <= 18'($urandom);
            go(i % 2, 1'b1, 8);
            chk(out_of(i % 2), fd[i%2]);
            chk(i % 2 ? a_oe_n : b_oe_n, exp_oe(1'b1, 1'b0));
        end
        for (int d = 0; d < 2; d++)
        begin
            foreach (v[k]) v[k] = 18'($urandom);
            fd[d] <= v[0];
            go(d, 1'b1, 8);
            go(d, 1'b0, 1);
            fd[d] <= v[1];
            repeat (5) @(posedge hclk);
            chk(out_of(d), v[0]);
            ahb(1'b0, 32'(d * 4), 32'h0000_0000, rd);
            chk(rd, 32'(v[0]));
            ctl[d].clk_gate_n <= 1'b0;
            repeat (3) @(posedge hclk);
            pulse(d);
            chk(out_of(d), v[1]);
            ctl[d].clk_gate_n <= 1'b1;
            fd[d] <= v[2];
            repeat (3) @(posedge hclk);
            pulse(d);
            chk(out_of(d), v[1]);
            ctl[d].out_en_n <= 1'b1;
            ctl[d].latch_en <= 1'b1;
            repeat (8) @(posedge hclk);
            chk(d ? a_oe_n : b_oe_n, exp_oe(1'b1, 1'b1));
            chk(out_of(d), v[2]);
        end
        ahb(1'b1, 32'h0000_000C, 32'h0000_0000, rd);
        go(0, 1'b0, 5);
        chk(b_oe_n, exp_oe(1'b0, 1'b0));
        ahb(1'b1, 32'h0000_000C, 32'h0000_0003, rd);
        repeat (5) @(posedge hclk);
        chk(b_oe_n, exp_oe(1'b1, 1'b0));
        end_sim();
    end
endmodule
